// [hdl/qec_core.sv]
// Edge decoder and wrapping position counter for one encoder channel
`timescale 1ns/1ns
`default_nettype none
module qec_core #(
    parameter int W = qec_pkg::CNT_W
) (
    input wire logic sys_clk_i, // System clock
    input wire logic sys_rst_i, // Synchronous reset, high
    input wire qec_pkg::qec_trk_t trk_i, // Clean tracks
    input wire qec_pkg::qec_cfg_t cfg_i, // Channel settings
    input wire logic [W-1:0] max_i, // Wrap value
    output logic [W-1:0] count_o, // Position count
    output logic dir_o, // Last counted direction
    output logic up_o, // Counted forward edge pulse
    output logic dn_o, // Counted reverse edge pulse
    output logic idx_o // Index rise pulse
);
    import qec_pkg::*;

    qec_trk_t prev_ff;
    logic [W-1:0] count_ff;
    logic dir_ff;
    logic up_ff;
    logic dn_ff;
    logic idx_ff;
    logic a_chg;
    logic b_chg;
    logic fwd;
    logic take;
    logic up;
    logic dn;
    logic idx_rise;

    always_comb begin
        a_chg = trk_i.a ^ prev_ff.a;
        b_chg = trk_i.b ^ prev_ff.b;
        // Quadrature order, optionally swapped by software
        fwd = (prev_ff.b ^ trk_i.a) ^ cfg_i.dir_inv;
        unique case (cfg_i.mode)
            MODE_X2: take = a_chg & ~b_chg;
            MODE_X1: take = a_chg & ~b_chg & trk_i.a;
            default: take = a_chg ^ b_chg;
        endcase
        up = take & fwd;
        dn = take & ~fwd;
        // Index ignored entirely while disabled
        idx_rise = cfg_i.idx_en & trk_i.idx & ~prev_ff.idx;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= trk_i;
        end
    end

    // Index clear has priority over a coincident edge
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            count_ff <= '0;
        end else if (idx_rise && cfg_i.idx_rst) begin
            count_ff <= '0;
        end else if (up) begin
            // Greater-or-equal keeps the count in range if max shrinks
            count_ff <= (count_ff >= max_i) ? '0 : count_ff + 1'b1;
        end else if (dn) begin
            count_ff <= (count_ff == '0) ? max_i : count_ff - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dir_ff <= 1'b0;
        end else if (up) begin
            dir_ff <= 1'b1;
        end else if (dn) begin
            dir_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            up_ff <= 1'b0;
            dn_ff <= 1'b0;
            idx_ff <= 1'b0;
        end else begin
            up_ff <= up;
            dn_ff <= dn;
            idx_ff <= idx_rise;
        end
    end

    assign count_o = count_ff;
    assign dir_o = dir_ff;
    assign up_o = up_ff;
    assign dn_o = dn_ff;
    assign idx_o = idx_ff;
endmodule
`default_nettype wire

// [hdl/qec_pkg.sv]
// Constants and types shared by the quadrature encoder counter files
package qec_pkg;
    // Two independent counter channels
    localparam int NCH = 2;
    localparam int CNT_W = 32;
    localparam int DELTA_W = 16;

    // Clock rate and default step interval
    localparam int CLK_HZ = 20_000_000;
    localparam int STEP_US = 1000;
    localparam logic [31:0] STEP_CYC = 32'(CLK_HZ / 1_000_000 * STEP_US);

    // Register offsets inside one channel window of 32 bytes
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_MAX = 5'h04;
    localparam logic [4:0] OFS_STEP = 5'h08;
    localparam logic [4:0] OFS_SCALE = 5'h0c;
    localparam logic [4:0] OFS_CNT = 5'h10;
    localparam logic [4:0] OFS_VEL = 5'h14;
    localparam logic [4:0] OFS_STAT = 5'h18;
    // Address bit that selects the channel window
    localparam int CH_BIT = 5;

    // Counted edges
    localparam logic [1:0] MODE_X4 = 2'h0;
    localparam logic [1:0] MODE_X2 = 2'h1;
    localparam logic [1:0] MODE_X1 = 2'h2;

    // Values after reset
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [31:0] MAX_RST = 32'h0000_0fff;
    localparam logic [31:0] SCALE_RST = 32'h0000_0000;

    // Control register layout, bits 5..0
    typedef struct packed {
        logic idx_en;
        logic diff;
        logic idx_rst;
        logic dir_inv;
        logic [1:0] mode;
    } qec_cfg_t;

    // Encoder pins of one channel, true and complement
    typedef struct packed {
        logic idx_n;
        logic idx;
        logic b_n;
        logic b;
        logic a_n;
        logic a;
    } qec_pins_t;

    // Resolved tracks of one channel
    typedef struct packed {
        logic idx;
        logic b;
        logic a;
    } qec_trk_t;
endpackage

// [hdl/qec_top.sv]
// Two-channel quadrature encoder counter with APB register access
//
// Functional notes
// - Count direction follows quadrature edge order
// - Direction setting picks the incrementing order
// - Forward edge at maximum wraps to zero
// - Reverse edge at zero loads maximum
// - Enabled index rise clears the count when the reset method selects index clear
// - Reset method chooses index clear or wrap
// - Counter mode picks which edges count
// - Count and velocity in rad/s are readable
// - Status holds direction and index-in-last-step
// - Input type picks single-ended or differential
// - Single-ended mode ignores complement inputs
// - Disabled index never clears the count
// - Two independent channels with own settings
`timescale 1ns/1ns
`default_nettype none
module qec_top (
    input wire logic sys_clk_i, // System clock, 20 MHz
    input wire logic sys_rst_i, // Synchronous reset, high
    input wire logic [7:0] paddr_i, // APB byte address
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB write
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error
    input wire qec_pkg::qec_pins_t enc_pins_i [qec_pkg::NCH], // Encoder pins
    output logic [qec_pkg::NCH-1:0] dir_o, // Direction per channel
    output logic [qec_pkg::NCH-1:0] idx_flag_o // Index in last step
);
    import qec_pkg::*;

    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [NCH-1:0] dir_ff;
    logic [NCH-1:0] idx_flag_ff;

    // Register bank, one entry per channel
    qec_cfg_t cfg_ff [NCH];
    logic [CNT_W-1:0] max_ff [NCH];
    logic [31:0] step_ff [NCH];
    logic [31:0] scale_ff [NCH];
    logic [31:0] vel_ff [NCH];
    logic [CNT_W-1:0] count_w [NCH];
    logic [NCH-1:0] dir_w;

    // Bus decode
    logic access;
    logic commit;
    logic ch_sel;
    logic [4:0] reg_ofs;
    logic in_range;
    logic rd_ok;
    logic [31:0] rd_data;

    always_comb begin
        access = psel_i & penable_i & ~pready_ff;
        commit = psel_i & penable_i & pready_ff;
        ch_sel = paddr_i[CH_BIT];
        reg_ofs = paddr_i[4:0];
        in_range = (paddr_i[7:6] == 2'h0);
    end

    // Read mux and address check
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = in_range;
        unique case (reg_ofs)
            OFS_CTRL: rd_data = {26'h0, cfg_ff[ch_sel]};
            OFS_MAX: rd_data = max_ff[ch_sel];
            OFS_STEP: rd_data = step_ff[ch_sel];
            OFS_SCALE: rd_data = scale_ff[ch_sel];
            OFS_CNT: rd_data = count_w[ch_sel];
            OFS_VEL: rd_data = vel_ff[ch_sel];
            OFS_STAT: rd_data = {30'h0, idx_flag_ff[ch_sel], dir_w[ch_sel]};
            default: rd_ok = 1'b0;
        endcase
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= access;
        end
    end

    // Data and error are settled before ready is sampled
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (access) begin
            prdata_ff <= (rd_ok && !pwrite_i) ? rd_data : 32'h0000_0000;
            pslverr_ff <= ~rd_ok;
        end else if (!psel_i) begin
            pslverr_ff <= 1'b0;
        end
    end

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            qec_pins_t s1_ff;
            qec_pins_t s2_ff;
            qec_trk_t trk_ff;
            logic [31:0] step_cnt_ff;
            logic [DELTA_W-1:0] delta_ff;
            logic idx_seen_ff;
            logic [DELTA_W-1:0] delta_nx;
            logic signed [DELTA_W+31:0] prod;
            logic tick;
            logic wr;
            logic up;
            logic dn;
            logic idx;

            assign wr = commit & pwrite_i & in_range & (ch_sel == 1'(c));

            // Settings per channel, independent of the other channel
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    cfg_ff[c] <= CTRL_RST;
                    max_ff[c] <= MAX_RST;
                    step_ff[c] <= STEP_CYC;
                    scale_ff[c] <= SCALE_RST;
                end else if (wr) begin
                    unique case (reg_ofs)
                        OFS_CTRL: cfg_ff[c] <= pwdata_i[5:0];
                        OFS_MAX: max_ff[c] <= pwdata_i;
                        OFS_STEP: step_ff[c] <= pwdata_i;
                        OFS_SCALE: scale_ff[c] <= pwdata_i;
                        default: ;
                    endcase
                end
            end

            // Pins come from outside the clock domain
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    s1_ff <= '0;
                    s2_ff <= '0;
                end else begin
                    s1_ff <= enc_pins_i[c];
                    s2_ff <= s1_ff;
                end
            end

            // Differential pair with equal halves keeps last valid level
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    trk_ff <= '0;
                end else if (!cfg_ff[c].diff) begin
                    trk_ff <= {s2_ff.idx, s2_ff.b, s2_ff.a};
                end else begin
                    if (s2_ff.a ^ s2_ff.a_n) begin
                        trk_ff.a <= s2_ff.a;
                    end
                    if (s2_ff.b ^ s2_ff.b_n) begin
                        trk_ff.b <= s2_ff.b;
                    end
                    if (s2_ff.idx ^ s2_ff.idx_n) begin
                        trk_ff.idx <= s2_ff.idx;
                    end
                end
            end

            qec_core #(
                .W(CNT_W)
            ) u_core (
                .sys_clk_i(sys_clk_i),
                .sys_rst_i(sys_rst_i),
                .trk_i(trk_ff),
                .cfg_i(cfg_ff[c]),
                .max_i(max_ff[c]),
                .count_o(count_w[c]),
                .dir_o(dir_w[c]),
                .up_o(up),
                .dn_o(dn),
                .idx_o(idx)
            );

            // Step interval divider; zero or one gives a tick every cycle
            always_comb begin
                tick = ({1'b0, step_cnt_ff} + 33'h1) >= {1'b0, step_ff[c]};
                delta_nx = delta_ff + DELTA_W'(up) - DELTA_W'(dn);
                prod = $signed(delta_nx) * $signed(scale_ff[c]);
            end

            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    step_cnt_ff <= 32'h0000_0000;
                end else if (tick) begin
                    step_cnt_ff <= 32'h0000_0000;
                end else begin
                    step_cnt_ff <= step_cnt_ff + 32'h1;
                end
            end

            // Edges per step times rad per edge per second, Q16.16
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    delta_ff <= '0;
                    vel_ff[c] <= 32'h0000_0000;
                end else if (tick) begin
                    delta_ff <= '0;
                    vel_ff[c] <= prod[31:0];
                end else begin
                    delta_ff <= delta_nx;
                end
            end

            // Index arriving on the tick itself still counts for that step
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    idx_seen_ff <= 1'b0;
                    idx_flag_ff[c] <= 1'b0;
                end else if (tick) begin
                    idx_seen_ff <= 1'b0;
                    idx_flag_ff[c] <= idx_seen_ff | idx;
                end else if (idx) begin
                    idx_seen_ff <= 1'b1;
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    dir_ff[c] <= 1'b0;
                end else begin
                    dir_ff[c] <= dir_w[c];
                end
            end
        end
    endgenerate

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign dir_o = dir_ff;
    assign idx_flag_o = idx_flag_ff;
endmodule
`default_nettype wire

// [tb/qec_enc_model.sv]
// Behavioural incremental encoder for one channel
`timescale 1ns/1ns
`default_nettype none
module qec_enc_model #(
    parameter bit JUNK = 1'b0
) (
    input wire logic clk_i, // Clock
    output qec_pkg::qec_pins_t pins_o // Pins
);
    import qec_pkg::*;
    logic [1:0] ph = 2'h0;
    logic idx = 1'b0;
    logic [2:0] rnd = 3'h0;
    logic [2:0] trk;
    logic [2:0] cmp;
    // Phases 00,10,11,01 run forward
    assign trk = {idx, ph[1], ph[1] ^ ph[0]};
    // Unwired complements float, seen as noise
    assign cmp = JUNK ? rnd : ~trk;
    assign pins_o = {cmp[2], trk[2], cmp[1], trk[1], cmp[0], trk[0]};
    always_ff @(posedge clk_i) begin
        rnd <= 3'($urandom);
    end
    // inc 1 forward, 3 reverse, 2 both tracks at once
    task automatic step(input logic [1:0] inc, input int n);
        repeat (n) begin
            @(posedge clk_i);
            ph <= ph + inc;
            repeat (3) @(posedge clk_i);
        end
    endtask
    task automatic index();
        @(posedge clk_i);
        idx <= 1'b1;
        repeat (4) @(posedge clk_i);
        idx <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// [tb/qec_props.sv]
// Port-level checks for the encoder counter
`timescale 1ns/1ns
`default_nettype none
module qec_props (
    input wire logic sys_clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic [7:0] paddr_i, // Address
    input wire logic psel_i, // Select
    input wire logic penable_i, // Enable
    input wire logic pwrite_i, // Write
    input wire logic [31:0] pwdata_i, // Write data
    input wire logic [31:0] prdata_o, // Read data
    input wire logic pready_o, // Ready
    input wire logic pslverr_o, // Error
    input wire qec_pkg::qec_pins_t enc_pins_i [qec_pkg::NCH], // Pins
    input wire logic [qec_pkg::NCH-1:0] dir_o, // Direction
    input wire logic [qec_pkg::NCH-1:0] idx_flag_o // Index flag
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic acc = psel_i && penable_i && !pready_o;
    property p_wait;
        acc |=> pready_o;
    endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_cause;
        pready_o |-> $past(acc);
    endproperty
    a_cause: assert property (p_cause) else $error("ready unasked");
    property p_err0;
        pready_o && pslverr_o |-> prdata_o == 32'h0;
    endproperty
    a_err0: assert property (p_err0) else $error("error data");
    property p_hi;
        acc && paddr_i[7:6] != 2'h0 |=> pslverr_o;
    endproperty
    a_hi: assert property (p_hi) else $error("high address");
    property p_lo;
        acc && paddr_i[1:0] != 2'h0 |=> pslverr_o;
    endproperty
    a_lo: assert property (p_lo) else $error("misaligned");
    property p_wr0;
        acc && pwrite_i |=> prdata_o == 32'h0;
    endproperty
    a_wr0: assert property (p_wr0) else $error("write data");
    property p_ok;
        acc && paddr_i == {3'h0, qec_pkg::OFS_CNT} |=> !pslverr_o;
    endproperty
    a_ok: assert property (p_ok) else $error("count refused");
    // Pin to direction output is five edges deep, so six still samples freeze it
    property p_dir;
        $stable(enc_pins_i[0]) [*6] |-> $stable(dir_o[0]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction moved");
    property p_rst;
        @(posedge sys_clk_i) disable iff (1'b0)
        sys_rst_i |=> !pready_o && dir_o == 2'h0 && idx_flag_o == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    c_err: cover property (pready_o && pslverr_o);
    c_wr: cover property (pready_o && pwrite_i);
    c_rev: cover property ($fell(dir_o[0]));
endmodule
`default_nettype wire

// [tb/quadrature_encoder_counter_bench.sv]
// Self-checking bench for the two-channel encoder counter
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module quadrature_encoder_counter_bench;
    import qec_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] paddr = 8'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic [NCH-1:0] dir;
    wire logic [NCH-1:0] idx_flag;
    wire qec_pins_t pins [NCH];
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    logic [32:0] expq [$];
    logic [32:0] ex;
    logic [31:0] ecnt;
    logic [7:0] bad [4] = '{8'h1c, 8'h01, 8'h40, 8'hc4};
    qec_top i_qec_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .enc_pins_i(pins),
        .dir_o(dir), .idx_flag_o(idx_flag));
    qec_enc_model #(.JUNK(1'b0)) i_qec_enc_model0 (.clk_i(sys_clk_i), .pins_o(pins[0]));
    qec_enc_model #(.JUNK(1'b1)) i_qec_enc_model1 (.clk_i(sys_clk_i), .pins_o(pins[1]));
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    function automatic logic [7:0] ad(input logic ch, input logic [4:0] o);
        return {2'h0, ch, o};
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Request held until the rising edge that samples ready high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [32:0] e);
        expq.push_back(e);
        @(posedge sys_clk_i);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready !== 1'b1) @(posedge sys_clk_i);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        apb(a, 1'b0, 32'h0, {1'b0, v});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 33'h0);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge sys_clk_i);
    endtask
    always @(posedge sys_clk_i) begin
        if (psel && penable && pready === 1'b1) begin
            ex = expq.pop_front();
            `CHK("apb", ex, {pslverr, prdata})
        end
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        n = $urandom(56769);
        settle(16);
        sys_rst_i <= 1'b0;
        foreach (bad[k]) apb(bad[k], k[0], 32'h1, 33'h100000000);
        rd(ad(0, OFS_CTRL), {26'h0, CTRL_RST});
        rd(ad(0, OFS_MAX), MAX_RST);
        rd(ad(0, OFS_STEP), STEP_CYC);
        rd(ad(0, OFS_SCALE), SCALE_RST);
        wr(ad(0, OFS_CNT), 32'h7);
        rd(ad(0, OFS_CNT), 32'h0);
        wr(ad(0, OFS_STEP), 32'h64);
        wr(ad(0, OFS_SCALE), 32'h10000);
        ecnt = 32'h0;
        for (int m = 0; m < 4; m++) begin
            wr(ad(0, OFS_CTRL), 32'h38 + 32'(m));
            i_qec_enc_model0.step(2'h1, 4);
            ecnt += (m == 1) ? 2 : (m == 2) ? 1 : 4;
            settle(8);
            rd(ad(0, OFS_CNT), ecnt);
        end
        i_qec_enc_model0.step(2'h2, 1);
        settle(8);
        rd(ad(0, OFS_CNT), ecnt);
        i_qec_enc_model1.step(2'h3, 1);
        settle(8);
        rd(ad(1, OFS_CNT), MAX_RST);
        `CHK("dir", 2'h1, dir)
        wr(ad(0, OFS_MAX), 32'h7);
        n = $urandom_range(2, 5);
        i_qec_enc_model0.step(2'h1, n);
        settle(8);
        rd(ad(0, OFS_CNT), 32'(n - 1));
        i_qec_enc_model0.step(2'h3, n);
        settle(8);
        rd(ad(0, OFS_CNT), 32'h7);
        `CHK("dir", 1'b0, dir[0])
        i_qec_enc_model0.index();
        // Flag rises on a step tick; edges just after it share one step
        for (int w = 0; w < 120 && idx_flag[0] !== 1'b1; w++) settle(1);
        `CHK("flag", 1'b1, idx_flag[0])
        rd(ad(0, OFS_CNT), 32'h0);
        i_qec_enc_model0.step(2'h1, 2);
        settle(110);
        `CHK("flag", 1'b0, idx_flag[0])
        rd(ad(0, OFS_VEL), 32'h20000);
        wr(ad(0, OFS_CTRL), 32'h34);
        i_qec_enc_model0.step(2'h1, 1);
        i_qec_enc_model0.index();
        settle(8);
        rd(ad(0, OFS_CNT), 32'h1);
        wr(ad(0, OFS_CTRL), 32'h1c);
        i_qec_enc_model0.index();
        i_qec_enc_model0.step(2'h3, 1);
        settle(8);
        rd(ad(0, OFS_CNT), 32'h2);
        `CHK("dir", 1'b1, dir[0])
        settle(4);
        finish_test();
    end
endmodule
bind qec_top qec_props i_qec_props (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .enc_pins_i(enc_pins_i), .dir_o(dir_o),
    .idx_flag_o(idx_flag_o));
`default_nettype wire
